//--- logic/mir_pkg.sv
/*
 * Package for the motion and image status register block: register
 * indices, status bit positions, reset values and the carrier structs.
 * Assumes an APB master with 32-bit data and word-aligned registers.
 */
package mir_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_MODEL_IDENTITY   = 8'h00;
	localparam logic [7:0] IDX_FIRMWARE_REV     = 8'h01;
	localparam logic [7:0] IDX_MOVEMENT_STATUS  = 8'h02;
	localparam logic [7:0] IDX_X_DISP_LOW       = 8'h03;
	localparam logic [7:0] IDX_X_DISP_HIGH      = 8'h04;
	localparam logic [7:0] IDX_Y_DISP_LOW       = 8'h05;
	localparam logic [7:0] IDX_Y_DISP_HIGH      = 8'h06;
	localparam logic [7:0] IDX_SURFACE_QUALITY  = 8'h07;
	localparam logic [7:0] IDX_PIXEL_TOTAL_HIGH = 8'h08;
	localparam logic [7:0] IDX_BRIGHTEST_PIXEL  = 8'h09;
	localparam logic [7:0] IDX_DARKEST_PIXEL    = 8'h0a;
	localparam logic [7:0] IDX_EXPOSURE_LOW     = 8'h0b;
	localparam logic [7:0] IDX_LAST             = 8'h0b;

	// movement status bit positions
	localparam int BIT_MOVEMENT_FLAG  = 7;
	localparam int BIT_LASER_FAULT    = 6;
	localparam int BIT_LASER_POWER_OK = 5;
	localparam int BIT_ACTIVITY_HI    = 2;
	localparam int BIT_ACTIVITY_LO    = 1;
	localparam int BIT_FIRST_PIXEL    = 0;

	// reset values
	localparam logic [7:0] RST_STATUS   = 8'h00;
	localparam logic [7:0] RST_STAT     = 8'h00;
	localparam logic [7:0] RST_EXPOSURE = 8'h20;

	// image statistic ranges and scaling
	localparam int SUM_WIDTH        = 17;
	localparam int SUM_SHIFT        = 9;
	localparam int FEATURE_WIDTH    = 10;
	localparam int FEATURE_SHIFT    = 2;
	localparam logic [7:0] SQ_MAX   = 8'ha9;
	localparam logic [7:0] PIX_MAX  = 8'h7f;
	localparam logic [7:0] SUM_MAX  = 8'hdf;

	// internal oscillator rate in which exposure counts are expressed
	localparam int OSC_MHZ = 50;

	// one completed frame of statistics from the image pipeline
	typedef struct packed {
		logic [FEATURE_WIDTH-1:0] features;
		logic [SUM_WIDTH-1:0]     pixelSum;
		logic [6:0]               brightest;
		logic [6:0]               darkest;
		logic [15:0]              exposure;
	} mir_frame_s;

	// all state of the register block except the laser fault synchroniser
	typedef struct packed {
		logic              movementFlag;
		logic              snapValid;
		logic [15:0]       accX;
		logic [15:0]       accY;
		logic [15:0]       snapX;
		logic [15:0]       snapY;
		logic [7:0]        surfaceQuality;
		logic [7:0]        pixelTotalHigh;
		logic [7:0]        brightestPixel;
		logic [7:0]        darkestPixel;
		logic [7:0]        exposureLow;
		logic [31:0]       prdata;
	} mir_state_s;

endpackage

//--- logic/mir_status_regs.sv
/*
 * Register block of an optical navigation sensor: identity bytes, the
 * movement status byte with displacement snapshot, read-to-clear high
 * bytes and per-frame image statistics, all reached over APB.
 * Assumes the image pipeline delivers displacement steps and frame
 * statistics as single-cycle pulses on ref_clk; the laser fault pin is
 * asynchronous and is synchronised here.
 */
// Our own choice: the APB interface to the registers.
// How it works
// - identity byte at index zero is a constant parameter, never changes.
// - firmware revision byte at index one is a constant parameter.
// - status bit 7 set while unreported displacement has accumulated.
// - reading status freezes both displacement words into a snapshot.
// - rereading status before the displacement bytes replaces the old snapshot.
// - any status write clears movement flag and all displacement bytes.
// - status bit 6 reports laser drive shorted to ground.
// - status bit 5 high when laser power pair is complementary.
// - status bits 2:1 report run or rest level one to three.
// - status bit 0 high when frame capture word is pixel 0,0.
// - reading either high displacement byte clears that axis snapshot.
// - surface quality is features divided by four, capped at 169.
// - pixel total byte is bits 16:9 of the 17-bit frame sum, capped at 223.
// - brightest pixel byte is updated each frame, 0 to 127.
// - darkest pixel byte is updated each frame, 0 to 127.
// - exposure low byte at index 0x0b, reset value 0x20.
// - exposure counts are internal oscillator cycles at 50 MHz.
module mir_status_regs
	import mir_pkg::*;
#(
	parameter logic [7:0] MODEL_ID = 8'h5a,  // arbitrary value
	parameter logic [7:0] FW_REV   = 8'h01   // arbitrary value
)
(
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        motionValid,
	input  wire logic [15:0] motionDx,
	input  wire logic [15:0] motionDy,
	input  wire logic        frameDone,
	input  wire mir_frame_s  frameStats,
	input  wire logic        laserDriveShort,
	input  wire logic        laserPowerOk,
	input  wire logic [1:0]  activityLevel,
	input  wire logic        capturePixelFirst
);

	mir_state_s st;
	mir_state_s next_st;
	logic [1:0] faultSync;
	logic [7:0] statusByte;
	logic [7:0] regIdx;
	logic       addrOk;
	logic       rdSetup;
	logic       motionNow;
	logic       rdAcc;
	logic       wrAcc;
	logic [15:0] sumX;
	logic [15:0] sumY;
	logic [7:0]  sqRaw;
	logic [7:0]  sumRaw;

	// package constants that the byte slices, the register map and the exposure count rate depend on
	if (SUM_WIDTH - SUM_SHIFT != 8)
	begin : g_bad_sum
		$error("pixel total slice is not one byte wide");
	end
	if (FEATURE_WIDTH - FEATURE_SHIFT != 8)
	begin : g_bad_feature
		$error("surface quality slice is not one byte wide");
	end
	if (IDX_LAST != IDX_EXPOSURE_LOW)
	begin : g_bad_last
		$error("last register index does not match the exposure byte");
	end
	if (OSC_MHZ <= 0)
	begin : g_bad_osc
		$error("exposure count oscillator rate must be positive");
	end

	// laser fault pin is asynchronous: two flops before use
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			faultSync <= 2'b00;
		else
			faultSync <= {faultSync[0], laserDriveShort};
	end

	// zero-wait slave; read data is loaded during the setup cycle so it stands
	// at the access edge; unmapped or misaligned addresses answer with pslverr
	assign regIdx  = paddr[9:2];
	assign rdSetup = psel && !penable && !pwrite && addrOk;
	assign addrOk  = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00) && (regIdx <= IDX_LAST);
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !addrOk;
	assign rdAcc   = psel && penable && !pwrite && addrOk;
	assign wrAcc   = psel && penable && pwrite && addrOk;
	assign prdata  = st.prdata;

	// live status byte; reserved bits 4:3 read zero
	always_comb
	begin
		statusByte = RST_STATUS;
		statusByte[BIT_MOVEMENT_FLAG]  = st.movementFlag || motionNow;
		statusByte[BIT_LASER_FAULT]    = faultSync[1];
		statusByte[BIT_LASER_POWER_OK] = laserPowerOk;
		statusByte[BIT_ACTIVITY_HI]    = activityLevel[1];
		statusByte[BIT_ACTIVITY_LO]    = activityLevel[0];
		statusByte[BIT_FIRST_PIXEL]    = capturePixelFirst;
	end

	// a nonzero step in this cycle; counts toward the flag before it lands in acc
	assign motionNow = motionValid && ((motionDx != 16'h0000) || (motionDy != 16'h0000));

	// accumulators saturate nowhere: 16-bit wrap matches the reported width
	assign sumX = st.accX + (motionValid ? motionDx : 16'h0000);
	assign sumY = st.accY + (motionValid ? motionDy : 16'h0000);

	// statistic scaling, clamped to the documented maxima
	assign sqRaw  = frameStats.features[FEATURE_WIDTH-1:FEATURE_SHIFT];
	assign sumRaw = frameStats.pixelSum[SUM_WIDTH-1:SUM_SHIFT];

	// single next-state process for all of st; the fault synchroniser has its own flops
	always_comb
	begin
		next_st = st;
		next_st.accX = sumX;
		next_st.accY = sumY;
		// motion seen this cycle sets the flag; wins over a read snapshot clear
		if (motionNow)
			next_st.movementFlag = 1'b1;

		// per-frame statistics written in one cycle so reads never tear
		if (frameDone)
		begin
			next_st.surfaceQuality = (sqRaw > SQ_MAX) ? SQ_MAX : sqRaw;
			next_st.pixelTotalHigh = (sumRaw > SUM_MAX) ? SUM_MAX : sumRaw;
			next_st.brightestPixel = {1'b0, frameStats.brightest} & PIX_MAX;
			next_st.darkestPixel   = {1'b0, frameStats.darkest} & PIX_MAX;
			next_st.exposureLow    = frameStats.exposure[7:0];
		end

		// read data loads at the end of setup so it already stands when pready is sampled
		if (rdSetup)
		begin
			next_st.prdata = 32'h0000_0000;
			unique case (regIdx)
				IDX_MODEL_IDENTITY:   next_st.prdata[7:0] = MODEL_ID;
				IDX_FIRMWARE_REV:     next_st.prdata[7:0] = FW_REV;
				IDX_MOVEMENT_STATUS:  next_st.prdata[7:0] = statusByte;
				IDX_X_DISP_LOW:       next_st.prdata[7:0] = st.snapX[7:0];
				IDX_X_DISP_HIGH:      next_st.prdata[7:0] = st.snapX[15:8];
				IDX_Y_DISP_LOW:       next_st.prdata[7:0] = st.snapY[7:0];
				IDX_Y_DISP_HIGH:      next_st.prdata[7:0] = st.snapY[15:8];
				IDX_SURFACE_QUALITY:  next_st.prdata[7:0] = st.surfaceQuality;
				IDX_PIXEL_TOTAL_HIGH: next_st.prdata[7:0] = st.pixelTotalHigh;
				IDX_BRIGHTEST_PIXEL:  next_st.prdata[7:0] = st.brightestPixel;
				IDX_DARKEST_PIXEL:    next_st.prdata[7:0] = st.darkestPixel;
				IDX_EXPOSURE_LOW:     next_st.prdata[7:0] = st.exposureLow;
				default:              next_st.prdata = 32'h0000_0000;
			endcase
		end
		else if (psel && !penable && !pwrite)
			next_st.prdata = 32'h0000_0000;

		// side effects of a read happen only at the access edge
		if (rdAcc)
		begin
			unique case (regIdx)
				IDX_MOVEMENT_STATUS:
				begin
					// snapshot takes what built up; this cycle's step opens the next report
					next_st.snapX = st.accX;
					next_st.snapY = st.accY;
					next_st.snapValid = 1'b1;
					next_st.accX = motionValid ? motionDx : 16'h0000;
					next_st.accY = motionValid ? motionDy : 16'h0000;
					next_st.movementFlag = motionNow;
				end
				IDX_X_DISP_HIGH:
					next_st.snapX = 16'h0000;
				IDX_Y_DISP_HIGH:
				begin
					next_st.snapY = 16'h0000;
					next_st.snapValid = 1'b0;
				end
				default:
					next_st.snapValid = st.snapValid;
			endcase
		end

		// write to status discards everything, including motion of this cycle
		if (wrAcc && (regIdx == IDX_MOVEMENT_STATUS))
		begin
			next_st.movementFlag = 1'b0;
			next_st.accX = 16'h0000;
			next_st.accY = 16'h0000;
			next_st.snapX = 16'h0000;
			next_st.snapY = 16'h0000;
			next_st.snapValid = 1'b0;
		end
	end

	// state register
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			st                <= '0;
			st.surfaceQuality <= RST_STAT;
			st.exposureLow    <= RST_EXPOSURE;
		end
		else
			st <= next_st;
	end

	// a status write leaves no displacement behind
	a_status_write_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
		(wrAcc && regIdx == IDX_MOVEMENT_STATUS) |=> (!st.movementFlag && st.snapX == 16'h0000
		&& st.accX == 16'h0000))
		else $error("status write did not clear displacement");

	// high byte read clears that axis snapshot
	a_high_read_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
		(rdAcc && regIdx == IDX_X_DISP_HIGH) |=> (st.snapX == 16'h0000))
		else $error("x high read did not clear");

	// status read freezes accumulated motion into the snapshot
	a_status_read_freeze: assert property (@(posedge ref_clk) disable iff (!nrst)
		(rdAcc && regIdx == IDX_MOVEMENT_STATUS && !motionValid) |=> (st.snapX == $past(st.accX)
		&& st.accX == 16'h0000))
		else $error("status read did not freeze displacement");

	// second status read refreshes the snapshot from new accumulation
	a_reread_replace: assert property (@(posedge ref_clk) disable iff (!nrst)
		(rdAcc && regIdx == IDX_MOVEMENT_STATUS && st.snapValid) |=> (st.snapY == $past(st.accY)))
		else $error("reread did not replace snapshot");

	// identity byte is constant
	a_model_identity: assert property (@(posedge ref_clk) disable iff (!nrst)
		(rdAcc && regIdx == IDX_MODEL_IDENTITY) |-> (prdata == {24'h000000, MODEL_ID}))
		else $error("identity byte wrong");

	// revision byte is constant
	a_firmware_rev: assert property (@(posedge ref_clk) disable iff (!nrst)
		(rdAcc && regIdx == IDX_FIRMWARE_REV) |-> (prdata == {24'h000000, FW_REV}))
		else $error("revision byte wrong");

	// nonzero motion raises the flag unless a status write discards it
	a_motion_flag: assert property (@(posedge ref_clk) disable iff (!nrst)
		(motionValid && motionDx != 16'h0000 && !wrAcc) |=> st.movementFlag)
		else $error("motion flag not set");

	// status bits read back as their sources in the setup cycle
	a_status_bits: assert property (@(posedge ref_clk) disable iff (!nrst)
		(rdAcc && regIdx == IDX_MOVEMENT_STATUS) |-> (prdata[2:1] == $past(activityLevel)
		&& prdata[0] == $past(capturePixelFirst) && prdata[5] == $past(laserPowerOk)
		&& prdata[6] == $past(faultSync[1])))
		else $error("status bits wrong");

	// frame statistics land together and within range
	a_frame_update: assert property (@(posedge ref_clk) disable iff (!nrst)
		frameDone |=> (st.surfaceQuality <= SQ_MAX && st.pixelTotalHigh <= SUM_MAX
		&& st.brightestPixel == {1'b0, $past(frameStats.brightest)}
		&& st.darkestPixel == {1'b0, $past(frameStats.darkest)}
		&& st.exposureLow == $past(frameStats.exposure[7:0])))
		else $error("frame statistics not updated");

	// motion arriving during a status read stays for the next report
	a_keep_accumulating: assert property (@(posedge ref_clk) disable iff (!nrst)
		(rdAcc && regIdx == IDX_MOVEMENT_STATUS && motionValid) |=> (st.accX == $past(motionDx)))
		else $error("motion lost during freeze");

	// status flag shows motion known in the setup cycle
	a_status_flag_read: assert property (@(posedge ref_clk) disable iff (!nrst)
		(rdAcc && regIdx == IDX_MOVEMENT_STATUS) |-> (prdata[7] == $past(st.movementFlag || motionNow)))
		else $error("status flag read wrong");

	// a status read with no new step leaves the flag low
	a_flag_clears_read: assert property (@(posedge ref_clk) disable iff (!nrst)
		(rdAcc && regIdx == IDX_MOVEMENT_STATUS && !motionValid) |=> !st.movementFlag)
		else $error("flag not cleared by status read");

	// reserved status bits always read zero
	a_status_reserved: assert property (@(posedge ref_clk) disable iff (!nrst)
		(rdAcc && regIdx == IDX_MOVEMENT_STATUS) |-> (prdata[4:3] == 2'b00))
		else $error("reserved status bits set");

	// upper bus lanes never carry data
	a_upper_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
		prdata[31:8] == 24'h000000)
		else $error("upper read lanes not zero");

	// steps add into the accumulator while the bus is idle
	a_accumulate_x: assert property (@(posedge ref_clk) disable iff (!nrst)
		(motionValid && !psel) |=> (st.accX == $past(st.accX) + $past(motionDx)))
		else $error("x step not accumulated");

	// snapshot only moves on bus accesses
	a_snap_steady: assert property (@(posedge ref_clk) disable iff (!nrst)
		!psel |=> (st.snapX == $past(st.snapX) && st.snapY == $past(st.snapY)))
		else $error("snapshot changed without access");

	// low byte reads leave the snapshot alone
	a_x_low_keeps: assert property (@(posedge ref_clk) disable iff (!nrst)
		(rdAcc && regIdx == IDX_X_DISP_LOW) |=> (st.snapX == $past(st.snapX)))
		else $error("x low read disturbed snapshot");

	// x high byte comes from the frozen snapshot
	a_x_high_data: assert property (@(posedge ref_clk) disable iff (!nrst)
		(rdAcc && regIdx == IDX_X_DISP_HIGH) |-> (prdata[7:0] == $past(st.snapX[15:8])))
		else $error("x high byte wrong");

	// y low byte comes from the frozen snapshot
	a_y_low_data: assert property (@(posedge ref_clk) disable iff (!nrst)
		(rdAcc && regIdx == IDX_Y_DISP_LOW) |-> (prdata[7:0] == $past(st.snapY[7:0])))
		else $error("y low byte wrong");

	// y high byte read clears that axis and ends the report
	a_y_high_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
		(rdAcc && regIdx == IDX_Y_DISP_HIGH) |=> (st.snapY == 16'h0000 && !st.snapValid))
		else $error("y high read did not clear");

	// writes elsewhere leave motion state untouched
	a_write_no_effect: assert property (@(posedge ref_clk) disable iff (!nrst)
		(wrAcc && regIdx != IDX_MOVEMENT_STATUS && !motionValid)
		|=> (st.accX == $past(st.accX) && st.movementFlag == $past(st.movementFlag)))
		else $error("write to other index changed motion");

	// refused accesses leave the accumulator and movement flag alone; a refused read still zeroes the read data
	a_error_no_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
		(psel && penable && !addrOk && !motionValid)
		|=> (st.accX == $past(st.accX) && st.movementFlag == $past(st.movementFlag)))
		else $error("refused access changed motion");

	// refused accesses leave the snapshot alone
	a_error_no_read: assert property (@(posedge ref_clk) disable iff (!nrst)
		(psel && penable && !addrOk) |=> (st.snapX == $past(st.snapX) && st.snapY == $past(st.snapY)))
		else $error("refused access changed snapshot");

	// statistics hold between frames
	a_frame_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
		!frameDone |=> (st.surfaceQuality == $past(st.surfaceQuality)
		&& st.pixelTotalHigh == $past(st.pixelTotalHigh) && st.exposureLow == $past(st.exposureLow)))
		else $error("statistics changed between frames");

	// in-range feature count is passed through unclamped
	a_quality_scale: assert property (@(posedge ref_clk) disable iff (!nrst)
		(frameDone && sqRaw <= SQ_MAX) |=> (st.surfaceQuality == $past(sqRaw)))
		else $error("surface quality scaling wrong");

	// in-range pixel total is passed through unclamped
	a_sum_scale: assert property (@(posedge ref_clk) disable iff (!nrst)
		(frameDone && sumRaw <= SUM_MAX) |=> (st.pixelTotalHigh == $past(sumRaw)))
		else $error("pixel total scaling wrong");

	// surface quality never exceeds its ceiling
	a_quality_cap: assert property (@(posedge ref_clk) disable iff (!nrst)
		st.surfaceQuality <= SQ_MAX)
		else $error("surface quality above ceiling");

	// pixel total never exceeds its ceiling
	a_sum_cap: assert property (@(posedge ref_clk) disable iff (!nrst)
		st.pixelTotalHigh <= SUM_MAX)
		else $error("pixel total above ceiling");

	// brightest and darkest pixel stay seven bits
	a_pixel_range: assert property (@(posedge ref_clk) disable iff (!nrst)
		(st.brightestPixel <= PIX_MAX && st.darkestPixel <= PIX_MAX))
		else $error("pixel extreme out of range");

	// exposure byte read returns the value held in the setup cycle
	a_exposure_read: assert property (@(posedge ref_clk) disable iff (!nrst)
		(rdAcc && regIdx == IDX_EXPOSURE_LOW) |-> (prdata[7:0] == $past(st.exposureLow)))
		else $error("exposure byte read wrong");

endmodule

//--- test/mir_pipe_model.sv
/*
 * Image pipeline stand-in: one-cycle displacement steps and frame
 * statistics. Assumes the bench calls its tasks from one process.
 */
module mir_pipe_model
	import mir_pkg::*;
(
	input  wire logic   ref_clk,
	output logic        motionValid,
	output logic [15:0] motionDx,
	output logic [15:0] motionDy,
	output logic        frameDone,
	output mir_frame_s  frameStats
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle payload is junk so a late sample of it shows up
	initial
	begin
		motionValid = 1'b0;
		frameDone   = 1'b0;
		motionDx    = 16'h5555;
		motionDy    = 16'haaaa;
		frameStats  = '1;
	end

	// one step; payload inverted once the pulse is over
	task automatic step(input logic [15:0] dx, input logic [15:0] dy);
		@(posedge ref_clk);
		motionValid <= 1'b1;
		motionDx    <= dx;
		motionDy    <= dy;
		@(posedge ref_clk);
		motionValid <= 1'b0;
		motionDx    <= ~dx;
		motionDy    <= ~dy;
	endtask

	// one completed frame, all statistics in the same pulse
	task automatic frame(input mir_frame_s f);
		@(posedge ref_clk);
		frameDone  <= 1'b1;
		frameStats <= f;
		@(posedge ref_clk);
		frameDone  <= 1'b0;
		frameStats <= ~f;
	endtask
endmodule

//--- test/mir_status_regs_tb_top.sv
/*
 * Self-checking bench for the status register block over APB.
 * Assumes read data stands at the edge that samples pready high.
 */
module mir_status_regs_tb_top
	import mir_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [7:0] ID_VAL  = 8'h5a; // arbitrary value
	localparam logic [7:0] REV_VAL = 8'h01; // arbitrary value
	logic        ref_clk = 1'b0;
	logic        nrst = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic        laserDriveShort = 1'b0;
	logic        laserPowerOk = 1'b0;
	logic [1:0]  activityLevel = 2'h0;
	logic        capturePixelFirst = 1'b0;
	logic [31:0] prdata;
	logic        pready, pslverr, motionValid, frameDone;
	logic [15:0] motionDx, motionDy;
	mir_frame_s  frameStats;
	int          err_total = 0;
	int          checked = 0;
	mir_frame_s  frm [2] = '{{10'h3ff, 17'h1be7c, 7'h7f, 7'h00, 16'h4e31},
		{10'h008, 17'h003ff, 7'h00, 7'h7f, 16'h12ab}};
	logic [7:0]  expStat [2][5] = '{'{8'ha9, 8'hdf, 8'h7f, 8'h00, 8'h31},
		'{8'h02, 8'h01, 8'h00, 8'h7f, 8'hab}};
	logic [11:0] badAddr [3] = '{12'h030, 12'h005, 12'h404};

	always #12.5 ref_clk = ~ref_clk;

	mir_status_regs #(.MODEL_ID(ID_VAL), .FW_REV(REV_VAL)) dut (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .motionValid(motionValid), .motionDx(motionDx),
		.motionDy(motionDy), .frameDone(frameDone), .frameStats(frameStats),
		.laserDriveShort(laserDriveShort), .laserPowerOk(laserPowerOk), .activityLevel(activityLevel),
		.capturePixelFirst(capturePixelFirst));

	mir_pipe_model pipe (.ref_clk(ref_clk), .motionValid(motionValid), .motionDx(motionDx),
		.motionDy(motionDy), .frameDone(frameDone), .frameStats(frameStats));

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
			err_total++;
		end
	endtask

	// one APB transfer; response and read data taken at the edge that sees pready
	task automatic acc(input logic wr, input logic [11:0] a, input logic [7:0] exp, input logic expErr);
		int n;
		n = 0;
		@(posedge ref_clk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= 32'h0000_00ff;
		@(posedge ref_clk);
		penable <= 1'b1;
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
			err_total++;
		chk($sformatf("pslverr at %h", a), {31'h0, pslverr}, {31'h0, expErr});
		if (!wr)
			chk($sformatf("reg at %h", a), prdata, {24'h0, exp});
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic conclude();
		if (err_total == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// watchdog: the sequence needs well under a thousand cycles
	initial
	begin
		repeat (5000) @(posedge ref_clk);
		err_total++;
		conclude();
	end

	initial
	begin
		repeat (20) @(posedge ref_clk);
		nrst <= 1'b1;
		acc(0, 12'h000, ID_VAL, 0);
		acc(1, 12'h000, 8'h00, 0);
		acc(0, 12'h000, ID_VAL, 0);
		acc(0, 12'h004, REV_VAL, 0);
		acc(0, 12'h008, 8'h00, 0);
		acc(0, 12'h02c, 8'h20, 0);
		for (int k = 0; k < 4; k++)
			acc(0, 12'h01c + 12'(4 * k), 8'h00, 0);
		// every activity level, fault and pixel bits toggled against it
		for (int i = 0; i < 4; i++)
		begin
			@(posedge ref_clk);
			laserDriveShort   <= i[0];
			laserPowerOk      <= ~i[0];
			activityLevel     <= i[1:0];
			capturePixelFirst <= i[1];
			repeat (3) @(posedge ref_clk);
			acc(0, 12'h008, {1'b0, i[0], ~i[0], 2'b00, i[1:0], i[1]}, 0);
		end
		@(posedge ref_clk);
		laserDriveShort   <= 1'b0;
		activityLevel     <= 2'h0;
		capturePixelFirst <= 1'b0;
		repeat (3) @(posedge ref_clk);
		// snapshot read in ascending order while motion keeps coming
		pipe.step(16'h0100, 16'hfff0);
		pipe.step(16'h0023, 16'hffff);
		acc(0, 12'h008, 8'h80, 0);
		pipe.step(16'h0002, 16'h0003);
		acc(0, 12'h00c, 8'h23, 0);
		acc(0, 12'h010, 8'h01, 0);
		acc(0, 12'h014, 8'hef, 0);
		acc(0, 12'h018, 8'hff, 0);
		acc(0, 12'h010, 8'h00, 0);
		acc(0, 12'h008, 8'h80, 0);
		acc(0, 12'h00c, 8'h02, 0);
		acc(0, 12'h014, 8'h03, 0);
		acc(0, 12'h008, 8'h00, 0);
		// second status read without draining drops the first snapshot
		pipe.step(16'h0005, 16'h0006);
		acc(0, 12'h008, 8'h80, 0);
		pipe.step(16'h0007, 16'h0008);
		acc(0, 12'h008, 8'h80, 0);
		acc(0, 12'h00c, 8'h07, 0);
		acc(0, 12'h014, 8'h08, 0);
		pipe.step(16'h0009, 16'h0009);
		acc(1, 12'h008, 8'h00, 0);
		acc(0, 12'h008, 8'h00, 0);
		acc(0, 12'h00c, 8'h00, 0);
		acc(0, 12'h018, 8'h00, 0);
		// two frames: capped and full-scale values, then small ones
		for (int f = 0; f < 2; f++)
		begin
			pipe.frame(frm[f]);
			for (int k = 0; k < 5; k++)
				acc(0, 12'h01c + 12'(4 * k), expStat[f][k], 0);
		end
		acc(1, 12'h02c, 8'h00, 0);
		acc(0, 12'h02c, 8'hab, 0);
		for (int k = 0; k < 3; k++)
			acc(0, badAddr[k], 8'h00, 1);
		conclude();
	end
endmodule
